//--- rtl/uartt_map.vh
// register offsets, field positions and field encodings of the serial channel block
// assumes a 32-bit AHB-Lite bus with word aligned single transfers
`ifndef UARTT_MAP_VH
`define UARTT_MAP_VH

// ==========================================================
// register byte offsets
`define UARTT_OFS_CTRL     8'h00
`define UARTT_OFS_TXTHR    8'h04
`define UARTT_OFS_STATUS   8'h08
`define UARTT_OFS_DATA     8'h0C
`define UARTT_OFS_IRQST    8'h10
`define UARTT_OFS_IRQMSK   8'h14

// ==========================================================
// control fields
`define UARTT_MODE_LO      0
`define UARTT_MODE_HI      1
`define UARTT_LEN_LO       2
`define UARTT_LEN_HI       3
`define UARTT_MODE_ASYNC   2'h0
`define UARTT_MODE_COD8    2'h1
`define UARTT_MODE_COD16   2'h2
`define UARTT_MODE_AC97    2'h3
`define UARTT_LEN_BASE     4'h5

// ==========================================================
// status fields and threshold width
`define UARTT_ST_BRK       7
`define UARTT_ST_FE        6
`define UARTT_ST_TXSP      2
`define UARTT_ST_RXAV      0
`define UARTT_THR_W        5

// ==========================================================
// interrupt bits
`define UARTT_IRQ_RX       0
`define UARTT_IRQ_TX       1
`define UARTT_IRQ_BRK      2
`define UARTT_IRQ_FE       3
`define UARTT_IRQ_W        4

// ==========================================================
// receiver timing in serial clock ticks
`define UARTT_TICK_MID     4'h7
`define UARTT_TICK_LAST    4'hF
`define UARTT_BRK_HIGH     2'h2

// ==========================================================
// fifo shapes
`define UARTT_RXD          8
`define UARTT_RXP          3
`define UARTT_TXD          16
`define UARTT_TXP          4

`endif

//--- rtl/uartt_top.v
// second serial channel: tx empty threshold, rx break and framing status
// assumes serial tick and tx_load pulses are on hclk; rxd is an async pin
// Contract
// RQ1: threshold is five bits, zero to 31
// RQ2: software writes zero to upper threshold bits
// RQ3: tx fifo empty when bytes <= threshold
// RQ4: threshold serves this channel, all modes
// RQ5: one byte per sample, 8-bit modes
// RQ6: two bytes per sample, 16-bit modes
// RQ7: software scales threshold by bytes per sample
// RQ8: all-zero char without stop sets break
// RQ9: mid-char break needs next char low
// RQ10: a break takes one fifo entry
// RQ11: after break, wait two high ticks
// RQ12: break and framing valid only with data
// RQ13: modem mode reads break and framing zero
// RQ14: missing stop bit sets framing error
// RQ15: stop bit sampled mid first stop
// RQ16: break at bit 7, framing at 6
// RQ17: two-bit mode field, async at reset
// RQ18: tx load to threshold sets tx ready
// RQ19: flags stored with each received char
module uartt_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire        irq,
  input  wire        serial_tick,
  input  wire        rxd,
  input  wire        tx_load,
  output wire        tx_sample_valid,
  output reg  [15:0] tx_sample,
  output wire        tx_wide
);
`include "uartt_map.vh"

  // ==========================================================
  // bus slave
  reg        wr_ff;
  reg  [7:0] wa_ff;
  reg  [1:0] mode_ff;
  reg  [1:0] len_ff;
  reg  [4:0] thr_ff;
  reg  [3:0] imsk_ff;
  reg  [3:0] ist_ff;
  reg        txsp_ff;
  reg  [31:0] nxt_hrdata;
  wire       acc = hsel & htrans[1] & hready;
  wire       rd  = acc & ~hwrite;
  wire [7:0] ra  = haddr[7:0];
  wire       wdo = wr_ff;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h00;
    end
    else
    begin
      wr_ff <= acc & hwrite;
      wa_ff <= haddr[7:0];
    end

  // ==========================================================
  // control and threshold registers
  wire wctl = wdo & (wa_ff == `UARTT_OFS_CTRL);
  wire wthr = wdo & (wa_ff == `UARTT_OFS_TXTHR);
  wire wdat = wdo & (wa_ff == `UARTT_OFS_DATA);
  wire wist = wdo & (wa_ff == `UARTT_OFS_IRQST);
  wire wmsk = wdo & (wa_ff == `UARTT_OFS_IRQMSK);

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      mode_ff <= `UARTT_MODE_ASYNC;
      len_ff  <= 2'h3;
      thr_ff  <= 5'h00;
      imsk_ff <= 4'h0;
    end
    else
    begin
      // RQ17: mode select
      if (wctl)
        mode_ff <= hwdata[`UARTT_MODE_HI:`UARTT_MODE_LO];
      if (wctl)
        len_ff <= hwdata[`UARTT_LEN_HI:`UARTT_LEN_LO];
      // RQ1: five-bit threshold
      // RQ2: reserved bits dropped
      if (wthr)
        thr_ff <= hwdata[`UARTT_THR_W-1:0];
      if (wmsk)
        imsk_ff <= hwdata[`UARTT_IRQ_W-1:0];
    end

  wire modem = (mode_ff != `UARTT_MODE_ASYNC);
  // RQ6: two-byte samples
  assign tx_wide = mode_ff[1];

  // ==========================================================
  // transmit fifo, one sample per entry
  reg  [15:0] txm [0:`UARTT_TXD-1];
  reg  [3:0]  twp_ff;
  reg  [3:0]  trp_ff;
  reg  [4:0]  tcnt_ff;
  wire        tfull = (tcnt_ff == 5'h10);
  wire        tpush = wdat & ~tfull;
  wire        tpop  = tx_load & (tcnt_ff != 5'h00);
  wire [4:0]  nxt_tcnt = tcnt_ff + {4'h0, tpush} - {4'h0, tpop};
  // RQ5: byte count from samples
  // RQ6: counts step by two
  wire [5:0]  tbytes = tx_wide ? {nxt_tcnt, 1'b0} : {1'b0, nxt_tcnt};
  // RQ3: empty at or below threshold
  // RQ4: one threshold for all modes
  wire        tlow  = (tbytes <= {1'b0, thr_ff});

  assign tx_sample_valid = (tcnt_ff != 5'h00);

  genvar gi;
  generate
    for (gi = 0; gi < `UARTT_TXD; gi = gi + 1)
    begin : g_txm
      always @(posedge hclk)
        if (tpush && twp_ff == gi)
          txm[gi] <= hwdata[15:0];
    end
  endgenerate

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      twp_ff    <= 4'h0;
      trp_ff    <= 4'h0;
      tcnt_ff   <= 5'h00;
      tx_sample <= 16'h0000;
      txsp_ff   <= 1'b1;
    end
    else
    begin
      tcnt_ff <= nxt_tcnt;
      if (tpush)
        twp_ff <= twp_ff + 4'h1;
      if (tpop)
      begin
        trp_ff    <= trp_ff + 4'h1;
        tx_sample <= txm[trp_ff];
      end
      // RQ18: ready on load reaching threshold
      if (tpop && tlow)
        txsp_ff <= 1'b1;
      else if (!tlow)
        txsp_ff <= 1'b0;
    end

  // ==========================================================
  // receiver line synchroniser
  reg rxs1_ff;
  reg rxs2_ff;

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rxs1_ff <= 1'b1;
      rxs2_ff <= 1'b1;
    end
    else
    begin
      rxs1_ff <= rxd;
      rxs2_ff <= rxs1_ff;
    end

  // ==========================================================
  // receiver state machine
  localparam S_IDLE = 3'h0;
  localparam S_STRT = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_STOP = 3'h3;
  localparam S_BRKW = 3'h4;

  reg  [2:0] st_ff;
  reg  [3:0] tk_ff;
  reg  [2:0] bit_ff;
  reg  [7:0] sh_ff;
  reg  [1:0] hi_ff;
  reg        push_ff;
  reg        fe_ff;
  reg        brk_ff;
  wire [3:0] nbits = `UARTT_LEN_BASE + {2'h0, len_ff};

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      st_ff   <= S_IDLE;
      tk_ff   <= 4'h0;
      bit_ff  <= 3'h0;
      sh_ff   <= 8'h00;
      hi_ff   <= 2'h0;
      push_ff <= 1'b0;
      fe_ff   <= 1'b0;
      brk_ff  <= 1'b0;
    end
    else
    begin
      push_ff <= 1'b0;
      if (serial_tick)
      begin
        tk_ff <= tk_ff + 4'h1;
        case (st_ff)
          S_IDLE:
            if (!rxs2_ff)
            begin
              st_ff <= S_STRT;
              tk_ff <= 4'h0;
            end
          S_STRT:
            if (tk_ff == `UARTT_TICK_MID)
            begin
              st_ff  <= rxs2_ff ? S_IDLE : S_DATA;
              tk_ff  <= 4'h0;
              bit_ff <= 3'h0;
              sh_ff  <= 8'h00;
            end
          S_DATA:
            if (tk_ff == `UARTT_TICK_LAST)
            begin
              sh_ff[bit_ff] <= rxs2_ff;
              bit_ff <= bit_ff + 3'h1;
              if ({1'b0, bit_ff} == nbits - 4'h1)
                st_ff <= S_STOP;
            end
          S_STOP:
            // RQ15: mid stop sample
            if (tk_ff == `UARTT_TICK_LAST)
            begin
              push_ff <= 1'b1;
              // RQ14: no stop bit
              fe_ff <= ~rxs2_ff;
              // RQ8: all-zero char, no stop
              // RQ9: mid-char break caught next char
              brk_ff <= ~rxs2_ff & (sh_ff == 8'h00);
              st_ff  <= (~rxs2_ff & (sh_ff == 8'h00)) ? S_BRKW : S_IDLE;
              hi_ff  <= 2'h0;
            end
          S_BRKW:
          begin
            // RQ11: line high two ticks
            hi_ff <= rxs2_ff ? hi_ff + 2'h1 : 2'h0;
            if (rxs2_ff && hi_ff == `UARTT_BRK_HIGH - 2'h1)
              st_ff <= S_IDLE;
          end
          default:
            st_ff <= S_IDLE;
        endcase
      end
    end

  // ==========================================================
  // receive fifo, char with its own flags
  reg  [9:0] rxm [0:`UARTT_RXD-1];
  reg  [2:0] rwp_ff;
  reg  [2:0] rrp_ff;
  reg  [3:0] rcnt_ff;
  wire       rav   = (rcnt_ff != 4'h0);
  // RQ10: one entry per break
  wire       rpush = push_ff & (rcnt_ff != 4'h8);
  wire       rpop  = rd & (ra == `UARTT_OFS_DATA) & rav;
  wire [9:0] rhead = rxm[rrp_ff];

  generate
    for (gi = 0; gi < `UARTT_RXD; gi = gi + 1)
    begin : g_rxm
      // RQ19: flags stored per char
      always @(posedge hclk)
        if (rpush && rwp_ff == gi)
          rxm[gi] <= {brk_ff, fe_ff, sh_ff};
    end
  endgenerate

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rwp_ff  <= 3'h0;
      rrp_ff  <= 3'h0;
      rcnt_ff <= 4'h0;
    end
    else
    begin
      rcnt_ff <= rcnt_ff + {3'h0, rpush} - {3'h0, rpop};
      if (rpush)
        rwp_ff <= rwp_ff + 3'h1;
      if (rpop)
        rrp_ff <= rrp_ff + 3'h1;
    end

  // ==========================================================
  // status word
  reg [7:0] stat;

  always @*
  begin
    stat = 8'h00;
    // RQ12: flags only with data
    // RQ13: zero in modem mode
    // RQ16: break bit 7, framing bit 6
    stat[`UARTT_ST_BRK]  = rav & ~modem & rhead[9];
    stat[`UARTT_ST_FE]   = rav & ~modem & rhead[8];
    stat[`UARTT_ST_TXSP] = txsp_ff;
    stat[`UARTT_ST_RXAV] = rav;
  end

  // ==========================================================
  // interrupt status, write one to clear, set wins
  wire [3:0] iev;
  assign iev[`UARTT_IRQ_RX]  = rpush;
  assign iev[`UARTT_IRQ_TX]  = tpop & tlow;
  assign iev[`UARTT_IRQ_BRK] = rpush & brk_ff;
  assign iev[`UARTT_IRQ_FE]  = rpush & fe_ff;

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ist_ff <= 4'h0;
    else
      ist_ff <= iev | (ist_ff & ~(wist ? hwdata[3:0] : 4'h0));

  assign irq = |(ist_ff & imsk_ff);

  // ==========================================================
  // read data, registered in the address phase
  always @*
  begin
    nxt_hrdata = 32'h00000000;
    case (ra)
      `UARTT_OFS_CTRL:
        nxt_hrdata = {28'h0000000, len_ff, mode_ff};
      `UARTT_OFS_TXTHR:
        nxt_hrdata = {27'h0000000, thr_ff};
      `UARTT_OFS_STATUS:
        nxt_hrdata = {24'h000000, stat};
      `UARTT_OFS_DATA:
        nxt_hrdata = {24'h000000, rav ? rhead[7:0] : 8'h00};
      `UARTT_OFS_IRQST:
        nxt_hrdata = {28'h0000000, ist_ff};
      `UARTT_OFS_IRQMSK:
        nxt_hrdata = {28'h0000000, imsk_ff};
      default:
        nxt_hrdata = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd)
      hrdata <= nxt_hrdata;

endmodule // uartt_top

//--- tb/uartt_sva.sv
// port checker for the serial channel block
// assumes uartt_map.vh on the include path
`include "uartt_map.vh"
// ==========
// checker
module uartt_sva (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        irq,
  input logic        tx_load,
  input logic        tx_sample_valid,
  input logic [15:0] tx_sample,
  input logic        tx_wide
);
  timeunit 1ns;
  timeprecision 1ns;
  wire       tk = hsel && htrans[1] && hready;
  wire [7:0] a  = haddr[7:0];
  wire       rs = tk && !hwrite && a == `UARTT_OFS_STATUS;
  wire       rt = tk && !hwrite && a == `UARTT_OFS_TXTHR;
  wire       wd = tk && hwrite && a == `UARTT_OFS_DATA;
  wire       wc = tk && hwrite && a == `UARTT_OFS_CTRL;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  thr_width_a: assert property (rt |=> hrdata[31:5] == 27'h0)
    else $error("threshold read too wide");
  st_width_a: assert property (rs |=> hrdata[31:8] == 24'h0)
    else $error("status read too wide");
  flags_idle_a: assert property (rs |=> hrdata[0] || hrdata[7:6] == 2'h0)
    else $error("flags set with no char");
  modem_zero_a: assert property (rs && tx_wide |=> hrdata[7:6] == 2'h0)
    else $error("flags set in modem mode");
  txs_hold_a: assert property (!(tx_load && tx_sample_valid) |=> $stable(tx_sample))
    else $error("sample moved without load");
  txv_rise_a: assert property ($rose(tx_sample_valid) |-> $past(wd, 2))
    else $error("valid rose without write");
  txv_fall_a: assert property ($fell(tx_sample_valid) |-> $past(tx_load))
    else $error("valid fell without load");
  mode_chg_a: assert property ($changed(tx_wide) |-> $past(wc, 2))
    else $error("width moved without ctrl write");
  cover property (rs ##1 hrdata[7]);
  cover property ($fell(tx_sample_valid));
  cover property ($rose(irq));
endmodule // uartt_sva

bind uartt_top uartt_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .irq, .tx_load, .tx_sample_valid, .tx_sample, .tx_wide);

//--- tb/uartt_peer.sv
// serial peer: receive line, serial ticks and transmit loads
// assumes hclk from the bench; one tick every two cycles
// ==========
// peer
module uartt_peer (
  input  logic hclk,
  output logic serial_tick,
  output logic rxd,
  output logic tx_load
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    serial_tick = 1'b0;
    rxd = 1'b1;
    tx_load = 1'b0;
  end
  always @(posedge hclk)
    serial_tick <= !serial_tick;
  task automatic bitt(input logic v);
    rxd <= v;
    repeat (32) @(posedge hclk);
  endtask
  task automatic send(input logic [7:0] c, input logic stp, input int lows);
    int i;
    @(posedge hclk);
    bitt(1'b0);
    for (i = 0; i < 8; i++)
      bitt(c[i]);
    bitt(stp);
    for (i = 0; i < lows; i++)
      bitt(1'b0);
    bitt(1'b1);
    bitt(1'b1);
  endtask
  task automatic load;
    @(posedge hclk);
    tx_load <= 1'b1;
    @(posedge hclk);
    tx_load <= 1'b0;
  endtask
endmodule // uartt_peer

//--- tb/testbench.sv
// self-checking bench for the serial channel block
// assumes uartt_top, uartt_peer and uartt_sva compiled first
`include "uartt_map.vh"
// ==========
// bench top
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic        tick;
  logic        rxd;
  logic        tx_load;
  logic        txv;
  logic [15:0] txs;
  logic        tx_wide;
  logic [31:0] rv;
  int          fails = 0;
  int          n_checks = 0;
  always #50 hclk = ~hclk;
  uartt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .irq(irq), .serial_tick(tick),
    .rxd(rxd), .tx_load(tx_load), .tx_sample_valid(txv), .tx_sample(txs),
    .tx_wide(tx_wide));
  uartt_peer peer (.hclk(hclk), .serial_tick(tick), .rxd(rxd), .tx_load(tx_load));
  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt;
    int i;
    for (i = 0; i < 50; i++)
    begin
      @(posedge hclk);
      if (hready === 1'b1)
        return;
    end
    fails++;
    stop_test();
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rv = hrdata;
  endtask
  task automatic pop(input logic [15:0] s, input logic [31:0] st);
    peer.load();
    @(posedge hclk);
    chk({16'h0, txs}, {16'h0, s});
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv, st);
  endtask
  task automatic t_reset;
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv, 32'h04);
    chk({31'h0, hresp}, 32'h0);
    xfer(`UARTT_OFS_CTRL, 1'b0, 32'h0);
    chk(rv, 32'h0C);
    xfer(8'h1C, 1'b0, 32'h0);
    chk(rv, 32'h0);
    xfer(`UARTT_OFS_TXTHR, 1'b1, 32'h1F);
    xfer(`UARTT_OFS_TXTHR, 1'b0, 32'h0);
    chk(rv, 32'h1F);
    $display("test reset done");
  endtask
  task automatic t_tx;
    int i;
    xfer(`UARTT_OFS_TXTHR, 1'b1, 32'h02);
    for (i = 1; i < 5; i++)
      xfer(`UARTT_OFS_DATA, 1'b1, 32'h11 * i);
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv, 32'h00);
    pop(16'h0011, 32'h00);
    pop(16'h0022, 32'h04);
    xfer(`UARTT_OFS_CTRL, 1'b1, 32'h0F);
    @(posedge hclk);
    chk({31'h0, tx_wide}, 32'h1);
    xfer(`UARTT_OFS_TXTHR, 1'b1, 32'h04);
    xfer(`UARTT_OFS_DATA, 1'b1, 32'h5566);
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv, 32'h00);
    pop(16'h0033, 32'h04);
    pop(16'h0044, 32'h04);
    pop(16'h5566, 32'h04);
    chk({31'h0, txv}, 32'h0);
    pop(16'h5566, 32'h04);
    xfer(`UARTT_OFS_CTRL, 1'b1, 32'h0C);
    $display("test tx done");
  endtask
  task automatic t_irq;
    xfer(`UARTT_OFS_IRQST, 1'b0, 32'h0);
    chk(rv, 32'h02);
    chk({31'h0, irq}, 32'h0);
    xfer(`UARTT_OFS_IRQMSK, 1'b1, 32'h02);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    xfer(`UARTT_OFS_IRQST, 1'b1, 32'h02);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask
  task automatic rxchk(input logic [7:0] c, input logic [31:0] st);
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv & 32'hC1, st);
    xfer(`UARTT_OFS_DATA, 1'b0, 32'h0);
    chk(rv, {24'h0, c});
  endtask
  task automatic t_rx;
    peer.send(8'hA5, 1'b1, 0);
    rxchk(8'hA5, 32'h01);
    peer.send(8'h3C, 1'b0, 0);
    rxchk(8'h3C, 32'h41);
    peer.send(8'h00, 1'b0, 10);
    rxchk(8'h00, 32'hC1);
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv & 32'hC1, 32'h0);
    peer.send(8'h5A, 1'b1, 0);
    rxchk(8'h5A, 32'h01);
    xfer(`UARTT_OFS_IRQST, 1'b0, 32'h0);
    chk(rv, 32'h0D);
    peer.send(8'h0F, 1'b0, 10);
    rxchk(8'h0F, 32'h41);
    rxchk(8'h00, 32'hC1);
    xfer(`UARTT_OFS_CTRL, 1'b1, 32'h0E);
    peer.send(8'h00, 1'b0, 0);
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv & 32'hC1, 32'h01);
    xfer(`UARTT_OFS_CTRL, 1'b1, 32'h0D);
    xfer(`UARTT_OFS_STATUS, 1'b0, 32'h0);
    chk(rv & 32'hC1, 32'h01);
    xfer(`UARTT_OFS_CTRL, 1'b1, 32'h0C);
    $display("test rx done");
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_tx();
    t_irq();
    t_rx();
    stop_test();
  end
endmodule // testbench
